//--- rtl/dect_top.v
// dual edge capture controller of a 16-bit timer channel pair
`timescale 1ns/100ps
`default_nettype none
`include "dect_regs.vh"
module dect_top (
	// clock and reset
	input wire clk_sys,
	input wire resetn,
	// mode and configuration
	input wire timer_feature_enable,
	input wire dual_capture_enable,
	input wire mode_select_a,
	input wire center_aligned_select,
	input wire [1:0] clock_source_select,
	input wire [1:0] even_edge_level_select,
	input wire [1:0] odd_edge_level_select,
	input wire [1:0] even_output_compare,
	input wire background_debug,
	// software strobes, one cycle each
	input wire capture_arm_set,
	input wire capture_arm_clear,
	input wire even_flag_clear,
	input wire odd_flag_clear,
	input wire overflow_flag_clear,
	input wire fault_flag_clear,
	input wire fault_event,
	input wire even_value_read,
	// modulo, initial count and byte writes
	input wire [15:0] initial_count,
	input wire [7:0] write_data,
	input wire modulo_high_write,
	input wire modulo_low_write,
	input wire value_high_write,
	input wire value_low_write,
	input wire timer_status_control_write,
	input wire channel_status_control_write,
	input wire counter_byte_write,
	input wire pwm_sync,
	input wire sync_reinitialize,
	input wire init_event,
	input wire [1:0] output_initial_bit,
	// interrupt enables
	input wire overflow_irq_enable,
	input wire [1:0] channel_irq_enable,
	input wire fault_irq_enable,
	// external channel input pin
	input wire channel_in,
	// status outputs
	output reg capture_arm,
	output reg even_channel_flag,
	output reg odd_channel_flag,
	output reg overflow_flag,
	output reg fault_flag,
	output reg [7:0] even_value_high,
	output reg [7:0] even_value_low,
	output reg [7:0] odd_value_high,
	output reg [7:0] odd_value_low,
	output reg [15:0] counter,
	output reg [15:0] modulo_value,
	output reg [15:0] channel_value,
	output reg free_running,
	output reg [1:0] channel_out,
	output reg [1:0] channel_out_en,
	output reg overflow_irq,
	output reg [1:0] channel_irq,
	output reg fault_irq
);
	// ----------------------------------------
	// input synchroniser
	// ----------------------------------------
	reg in_meta_reg;
	reg in_sync_reg;
	always @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			in_meta_reg <= 1'b0;
			in_sync_reg <= 1'b0;
		end else begin
			in_meta_reg <= channel_in;
			in_sync_reg <= in_meta_reg;
		end
	end

	// ----------------------------------------
	// edge selection
	// ----------------------------------------
	wire even_hit;
	wire odd_hit;
	// odd selection watches the even input too; equal selections give period
	dect_edge u_even_edge (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.level(in_sync_reg),
		.sel(even_edge_level_select),
		.hit(even_hit)
	);
	dect_edge u_odd_edge (
		.clk_sys(clk_sys),
		.resetn(resetn),
		.level(in_sync_reg),
		.sel(odd_edge_level_select),
		.hit(odd_hit)
	);

	// ----------------------------------------
	// capture control
	// ----------------------------------------
	wire dual_on;
	wire capt_ok;
	wire first_ev;
	wire second_ev;
	reg [15:0] even_buf_reg;
	reg [15:0] odd_buf_reg;
	assign dual_on = timer_feature_enable & dual_capture_enable;
	assign capt_ok = dual_on & capture_arm;
	// an edge matching both selections serves the pending stage only
	assign first_ev = capt_ok & even_hit & ~even_channel_flag;
	assign second_ev = capt_ok & odd_hit & even_channel_flag;
	always @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			capture_arm <= 1'b0;
			even_channel_flag <= 1'b0;
			odd_channel_flag <= 1'b0;
			even_buf_reg <= `DECT_CNT_RESET;
			odd_buf_reg <= `DECT_CNT_RESET;
			even_value_high <= 8'h00;
			even_value_low <= 8'h00;
			odd_value_high <= 8'h00;
			odd_value_low <= 8'h00;
		end else begin
			// single-shot disarms on the second edge; set beats clear
			if (second_ev && !mode_select_a)
				capture_arm <= 1'b0;
			else if (capture_arm_set)
				capture_arm <= 1'b1;
			else if (capture_arm_clear)
				capture_arm <= 1'b0;
			if (first_ev)
				even_channel_flag <= 1'b1;
			else if (even_flag_clear)
				even_channel_flag <= 1'b0;
			if (second_ev)
				odd_channel_flag <= 1'b1;
			else if (odd_flag_clear)
				odd_channel_flag <= 1'b0;
			// in continuous mode a fresh first edge re-enters without a flag clear
			if (first_ev || (capt_ok && even_hit && mode_select_a &&
			    !second_ev))
				even_buf_reg <= counter;
			if (second_ev) begin
				{even_value_high, even_value_low} <= even_buf_reg;
				odd_buf_reg <= counter;
			end
			// even value read keeps the pair coherent for software
			if (even_value_read)
				{odd_value_high, odd_value_low} <= odd_buf_reg;
		end
	end

	// ----------------------------------------
	// modulo and value write coherency
	// ----------------------------------------
	reg [7:0] mod_hi_buf_reg;
	reg mod_hi_ok_reg;
	reg [15:0] mod_buf_reg;
	reg mod_pend_reg;
	reg [7:0] val_hi_buf_reg;
	reg val_hi_ok_reg;
	reg [15:0] val_buf_reg;
	reg val_pend_reg;
	always @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			mod_hi_buf_reg <= 8'h00;
			mod_hi_ok_reg <= 1'b0;
			mod_buf_reg <= `DECT_MOD_RESET;
			mod_pend_reg <= 1'b0;
			modulo_value <= `DECT_MOD_RESET;
			val_hi_buf_reg <= 8'h00;
			val_hi_ok_reg <= 1'b0;
			val_buf_reg <= `DECT_CNT_RESET;
			val_pend_reg <= 1'b0;
			channel_value <= `DECT_CNT_RESET;
		end else begin
			if (modulo_high_write) begin
				mod_hi_buf_reg <= write_data;
				mod_hi_ok_reg <= 1'b1;
			end else if (modulo_low_write && mod_hi_ok_reg) begin
				mod_buf_reg <= {mod_hi_buf_reg, write_data};
				mod_pend_reg <= 1'b1;
				mod_hi_ok_reg <= 1'b0;
			end else if (timer_status_control_write &&
			    !timer_feature_enable) begin
				mod_hi_ok_reg <= 1'b0;
			end
			if (value_high_write) begin
				val_hi_buf_reg <= write_data;
				val_hi_ok_reg <= 1'b1;
			end else if (value_low_write && val_hi_ok_reg) begin
				val_buf_reg <= {val_hi_buf_reg, write_data};
				val_pend_reg <= 1'b1;
				val_hi_ok_reg <= 1'b0;
			end else if (channel_status_control_write &&
			    !timer_feature_enable) begin
				val_hi_ok_reg <= 1'b0;
			end
			// legacy mode loads at once; feature mode waits for sync
			if (mod_pend_reg && (!timer_feature_enable || pwm_sync)) begin
				modulo_value <= mod_buf_reg;
				mod_pend_reg <= 1'b0;
			end
			if (val_pend_reg && (!timer_feature_enable || pwm_sync)) begin
				channel_value <= val_buf_reg;
				val_pend_reg <= 1'b0;
			end
		end
	end

	// ----------------------------------------
	// counter, prescaler and free running
	// ----------------------------------------
	reg [1:0] presc_reg;
	wire restart;
	wire run;
	wire wrap;
	wire free_next;
	assign restart = counter_byte_write | (pwm_sync & sync_reinitialize);
	assign run = (clock_source_select != `DECT_CLOCK_SOURCE_SELECT_OFF) & ~background_debug;
	assign free_next = timer_feature_enable ?
	    (!center_aligned_select && initial_count == `DECT_FREE_LO &&
	    modulo_value == `DECT_FREE_HI) :
	    (modulo_value == `DECT_FREE_LO ||
	    modulo_value == `DECT_FREE_HI);
	assign wrap = free_next ? (counter == `DECT_FREE_HI) :
	    (counter == modulo_value);
	always @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			counter <= `DECT_CNT_RESET;
			presc_reg <= 2'h0;
			overflow_flag <= 1'b0;
			fault_flag <= 1'b0;
			free_running <= 1'b0;
		end else begin
			free_running <= free_next;
			// restart acts even in debug
			if (restart) begin
				counter <= initial_count;
				presc_reg <= 2'h0;
			end else if (run) begin
				counter <= wrap ? (free_next ? `DECT_CNT_RESET :
				    initial_count) : counter + 16'h0001;
			end
			if (run && wrap && !restart)
				overflow_flag <= 1'b1;
			else if (overflow_flag_clear)
				overflow_flag <= 1'b0;
			if (fault_event)
				fault_flag <= 1'b1;
			else if (fault_flag_clear)
				fault_flag <= 1'b0;
		end
	end

	// ----------------------------------------
	// channel outputs and interrupts
	// ----------------------------------------
	genvar gi;
	generate
		for (gi = 0; gi < 2; gi = gi + 1) begin : g_chan
			always @(posedge clk_sys or negedge resetn) begin
				if (!resetn) begin
					channel_out[gi] <= 1'b0;
					channel_out_en[gi] <= 1'b0;
				end else begin
					// pins only while a clock source is chosen
					channel_out_en[gi] <= (clock_source_select !=
					    `DECT_CLOCK_SOURCE_SELECT_OFF) && even_output_compare[gi];
					if (init_event)
						channel_out[gi] <= output_initial_bit[gi];
					else if (restart && !even_output_compare[gi])
						channel_out[gi] <= output_initial_bit[gi];
				end
			end
		end
	endgenerate
	// channel_out_en follows clock select and even_output_compare; dual capture does not mask the pin
	always @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			overflow_irq <= 1'b0;
			channel_irq <= 2'b00;
			fault_irq <= 1'b0;
		end else begin
			overflow_irq <= overflow_flag & overflow_irq_enable;
			channel_irq <= {odd_channel_flag, even_channel_flag} &
			    channel_irq_enable;
			fault_irq <= fault_flag & fault_irq_enable;
		end
	end
endmodule // dect_top
`default_nettype wire

//--- rtl/dect_regs.vh
// constants for the dual edge capture timer control block
`ifndef DECT_REGS_VH
`define DECT_REGS_VH
`define DECT_CNT_W 16
`define DECT_CNT_RESET 16'h0000
`define DECT_MOD_RESET 16'h0000
`define DECT_FREE_LO 16'h0000
`define DECT_FREE_HI 16'hFFFF
`define DECT_CLOCK_SOURCE_SELECT_OFF 2'h0
`define DECT_ELS_NONE 2'h0
`define DECT_ELS_RISE 2'h1
`define DECT_ELS_FALL 2'h2
`define DECT_ELS_BOTH 2'h3
`endif

//--- rtl/dect_edge.v
// edge detector for the synchronised even channel input
`timescale 1ns/100ps
`default_nettype none
`include "dect_regs.vh"
module dect_edge (
	// clock and reset
	input wire clk_sys,
	input wire resetn,
	// synchronised level and selection
	input wire level,
	input wire [1:0] sel,
	// detected selected edge, one-cycle pulse
	output reg hit
);
	reg prev_reg;
	wire rise;
	wire fall;
	assign rise = level & ~prev_reg;
	assign fall = ~level & prev_reg;
	always @(posedge clk_sys or negedge resetn) begin
		if (!resetn) begin
			prev_reg <= 1'b0;
			hit <= 1'b0;
		end else begin
			prev_reg <= level;
			case (sel)
			`DECT_ELS_RISE: hit <= rise;
			`DECT_ELS_FALL: hit <= fall;
			`DECT_ELS_BOTH: hit <= rise | fall;
			default: hit <= 1'b0;
			endcase
		end
	end
endmodule // dect_edge
`default_nettype wire

//--- tb/dect_chk.sv
// port checker for the dual edge capture controller
`timescale 1ns/100ps
`default_nettype none
module dect_chk (
	// clock and reset
	input wire logic clk_sys, resetn,
	// watched inputs
	input wire logic timer_feature_enable, dual_capture_enable,
	input wire logic mode_select_a, background_debug, pwm_sync,
	input wire logic counter_byte_write, even_value_read,
	input wire logic overflow_irq_enable, fault_irq_enable,
	input wire logic [1:0] clock_source_select, channel_irq_enable,
	// watched outputs
	input wire logic capture_arm, even_channel_flag, odd_channel_flag,
	input wire logic overflow_flag, fault_flag, overflow_irq, fault_irq,
	input wire logic [1:0] channel_irq, channel_out, channel_out_en,
	input wire logic [7:0] odd_value_high, odd_value_low,
	input wire logic [15:0] counter
);
	default clocking @(posedge clk_sys); endclocking
	default disable iff (!resetn);
	// ----
	// measurement steps
	// ----
	sequence s_second;
		$rose(odd_channel_flag);
	endsequence
	sequence s_shot_done;
		s_second ##0 !$past(mode_select_a);
	endsequence
	// ----
	// properties
	// ----
	a_ovf_irq_and: assert property (
		overflow_irq == $past(overflow_flag && overflow_irq_enable))
		else $error("overflow irq wrong");
	a_fault_irq_and: assert property (
		fault_irq == $past(fault_flag && fault_irq_enable))
		else $error("fault irq wrong");
	a_chan_irq_and: assert property (
		channel_irq == $past({odd_channel_flag, even_channel_flag}
		& channel_irq_enable)) else $error("channel irq wrong");
	a_odd_after_even: assert property (
		s_second |-> $past(even_channel_flag))
		else $error("odd flag without even flag");
	a_arm_auto_clr: assert property (
		s_shot_done |-> !capture_arm) else $error("arm not cleared");
	a_cap_enabled: assert property (
		$rose(even_channel_flag) |-> $past(timer_feature_enable
		&& dual_capture_enable && capture_arm))
		else $error("capture while disabled");
	a_pins_need_clk: assert property (
		clock_source_select == 2'h0 && $past(clock_source_select) == 2'h0
		|-> channel_out_en == 2'h0) else $error("pin driven while stopped");
	a_odd_val_read: assert property (
		$changed({odd_value_high, odd_value_low}) |-> $past(even_value_read))
		else $error("odd value moved without read");
	// counter write and sync may still move a frozen counter
	a_debug_freeze: assert property (
		$past(background_debug) && !$past(counter_byte_write)
		&& !$past(pwm_sync) |-> $stable(counter))
		else $error("counter moved in debug");
	a_reset_quiet: assert property (
		!$past(resetn) |-> counter == 16'h0000 && channel_out == 2'h0
		&& !even_channel_flag && !overflow_flag && !fault_flag)
		else $error("outputs not clear after reset");
endmodule // dect_chk
bind dect_top dect_chk dect_chk_i (.*);
`default_nettype wire

//--- tb/dect_pin.sv
// external signal source on the even channel input
`timescale 1ns/100ps
`default_nettype none
module dect_pin (
	// pin
	output var logic channel_in
);
	initial channel_in = 1'b0;
	// async source: levels move between clock edges
	task automatic level(input logic v);
		channel_in = v;
	endtask
endmodule // dect_pin
`default_nettype wire

//--- tb/tb_dual_edge_capture_timer_ctrl.sv
// testbench for the dual edge capture controller
`timescale 1ns/100ps
`default_nettype none
module tb_dual_edge_capture_timer_ctrl;
	logic clk_sys, resetn = '0, timer_feature_enable = '0;
	logic dual_capture_enable = '0, mode_select_a = '0, pwm_sync = '0;
	logic center_aligned_select = '0, background_debug = '0;
	logic capture_arm_set = '0, capture_arm_clear = '0, fault_event = '0;
	logic even_flag_clear = '0, odd_flag_clear = '0, init_event = '0;
	logic overflow_flag_clear = '0, fault_flag_clear = '0;
	logic even_value_read = '0, modulo_high_write = '0;
	logic modulo_low_write = '0, value_high_write = '0;
	logic value_low_write = '0, timer_status_control_write = '0;
	logic channel_status_control_write = '0, counter_byte_write = '0;
	logic sync_reinitialize = '0, overflow_irq_enable = '0;
	logic fault_irq_enable = '0;
	logic [1:0] clock_source_select = '0, even_edge_level_select = '0;
	logic [1:0] odd_edge_level_select = '0, even_output_compare = '0;
	logic [1:0] output_initial_bit = '0, channel_irq_enable = '0;
	logic [15:0] initial_count = '0;
	logic [7:0] write_data = '0;
	logic [1:0] channel_irq, channel_out, channel_out_en;
	logic [15:0] counter, modulo_value, channel_value;
	logic [7:0] even_value_high, even_value_low;
	logic [7:0] odd_value_high, odd_value_low;
	logic channel_in, capture_arm, even_channel_flag, odd_channel_flag;
	logic overflow_flag, fault_flag, free_running, overflow_irq, fault_irq;
	int mismatches = 0, num_checks = 0;
	logic [15:0] held;
	dect_top dect_top_i (.*);
	dect_pin dect_pin_i (.*);
	initial begin
		clk_sys = 1'b0;
		forever #20 clk_sys = ~clk_sys;
	end
	// ----
	// access tasks
	// ----
	task automatic tick(input int n);
		repeat (n) @(posedge clk_sys);
		#2;
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		tick(1);
		s = 1'b0;
	endtask
	task automatic check(input string what, input logic [15:0] seen, exp);
		num_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic finish_test;
		$display("checks %0d mismatches %0d", num_checks, mismatches);
		if (mismatches == 0 && num_checks > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// one measurement; gap is cycles between the two selected edges
	task automatic shot(input logic [1:0] es, os, input int gap,
		input logic cont);
		logic i;
		i = (es == 2'h2);
		even_edge_level_select = es;
		odd_edge_level_select = os;
		mode_select_a = cont;
		dect_pin_i.level(i);
		tick(5);
		pulse(even_flag_clear);
		pulse(odd_flag_clear);
		pulse(capture_arm_set);
		dect_pin_i.level(!i);
		tick(6);
		check("even flag", even_channel_flag, 1);
		check("odd flag early", odd_channel_flag, 0);
		if (os == es)
			dect_pin_i.level(i);
		tick(gap - 6);
		dect_pin_i.level((os == es) ^ i);
		tick(6);
		check("odd flag", odd_channel_flag, 1);
		check("arm", capture_arm, cont);
		pulse(even_value_read);
		tick(1);
		check("span", {odd_value_high, odd_value_low} -
			{even_value_high, even_value_low}, 16'(gap));
		pulse(capture_arm_clear);
		dect_pin_i.level(i);
		$display("test shot %0d done", gap);
	endtask
	// ----
	// tests
	// ----
	initial begin
		tick(12);
		resetn = 1'b1;
		tick(3);
		check("counter", counter, 16'h0000);
		check("pins", {channel_out, channel_out_en}, 4'h0);
		check("free", free_running, 1);
		timer_feature_enable = 1'b1;
		initial_count = 16'h0010;
		write_data = 8'hFF;
		pulse(modulo_high_write);
		pulse(modulo_low_write);
		tick(2);
		check("modulo held", modulo_value, 16'h0000);
		pulse(pwm_sync);
		tick(2);
		check("modulo", modulo_value, 16'hFFFF);
		check("free", free_running, 0);
		initial_count = 16'h0000;
		tick(2);
		check("free", free_running, 1);
		clock_source_select = 2'h1;
		even_edge_level_select = 2'h1;
		odd_edge_level_select = 2'h2;
		pulse(capture_arm_set);
		dect_pin_i.level(1'b1);
		tick(6);
		check("disabled", even_channel_flag, 0);
		dual_capture_enable = 1'b1;
		dect_pin_i.level(1'b0);
		tick(6);
		check("lone odd", odd_channel_flag, 0);
		pulse(capture_arm_clear);
		$display("test enables done");
		shot(2'h1, 2'h2, 20, 1'b0);
		shot(2'h2, 2'h1, 17, 1'b0);
		shot(2'h1, 2'h1, 25, 1'b0);
		shot(2'h2, 2'h2, 30, 1'b0);
		shot(2'h1, 2'h2, 15, 1'b1);
		channel_irq_enable = 2'h3;
		tick(2);
		check("chan irq", channel_irq, 2'h3);
		shot(2'h1, 2'h1, 40, 1'b1);
		fault_irq_enable = 1'b1;
		pulse(fault_event);
		tick(2);
		check("fault irq", {fault_flag, fault_irq}, 2'h3);
		pulse(fault_flag_clear);
		tick(2);
		check("fault irq", fault_irq, 0);
		background_debug = 1'b1;
		tick(1);
		held = counter;
		tick(5);
		check("frozen", counter, held);
		initial_count = 16'h0030;
		pulse(counter_byte_write);
		tick(3);
		check("reload", counter, 16'h0030);
		output_initial_bit = 2'h1;
		pulse(init_event);
		tick(2);
		check("init out", channel_out, 2'h1);
		background_debug = 1'b0;
		$display("test debug done");
		timer_feature_enable = 1'b0;
		overflow_irq_enable = 1'b1;
		write_data = 8'h00;
		pulse(modulo_high_write);
		pulse(timer_status_control_write);
		write_data = 8'h40;
		pulse(modulo_low_write);
		tick(2);
		check("mod coherency", modulo_value, 16'hFFFF);
		write_data = 8'h00;
		pulse(modulo_high_write);
		write_data = 8'h40;
		pulse(modulo_low_write);
		tick(2);
		check("modulo legacy", modulo_value, 16'h0040);
		check("free", free_running, 0);
		tick(12);
		check("overflow", {overflow_flag, overflow_irq}, 2'h3);
		check("wrap", counter, 16'h0034);
		write_data = 8'h12;
		pulse(value_high_write);
		pulse(channel_status_control_write);
		write_data = 8'h34;
		pulse(value_low_write);
		tick(2);
		check("value coherency", channel_value, 16'h0000);
		write_data = 8'h12;
		pulse(value_high_write);
		write_data = 8'h34;
		pulse(value_low_write);
		tick(2);
		check("value legacy", channel_value, 16'h1234);
		even_output_compare = 2'h2;
		tick(2);
		check("pin enable", channel_out_en, 2'h2);
		output_initial_bit = 2'h2;
		pulse(counter_byte_write);
		tick(2);
		check("oc kept", channel_out, 2'h0);
		$display("test legacy done");
		finish_test;
	end
	initial begin
		#200000;
		mismatches++;
		finish_test;
	end
endmodule // tb_dual_edge_capture_timer_ctrl
`default_nettype wire
